/* common/ssfl_pkg.sv */
package ssfl_pkg;
  localparam int NUM_CH = 4; // sequenced supplies
  localparam int CNT_W = 24; // width of delay and timeout counters
  // clock rate, step delay time and power-good timeout
  localparam int CLK_MHZ = 25;
  localparam int STEP_DELAY_US = 1000;
  localparam int STEP_DELAY_CYC = STEP_DELAY_US * CLK_MHZ;
  localparam int PGT_US = 10000;
  localparam int PGT_CYC = PGT_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] MIN_DELAY = 24'h00_0001; // minimum step delay
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [1:0] CH_FIRST = 2'h0;
  localparam logic [1:0] CH_LAST = 2'h3;
  localparam logic [NUM_CH-1:0] ALL_OFF = 4'h0;
  localparam logic [NUM_CH-1:0] ALL_ON = 4'hf;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    SS_IDLE = 7'h01,
    SS_UP_DLY = 7'h02,
    SS_UP_WAIT = 7'h04,
    SS_ON = 7'h08,
    SS_DN_DLY = 7'h10,
    SS_DN_WAIT = 7'h20,
    SS_FAULT = 7'h40
  } ssfl_state_type;

  // fault class flags
  typedef struct packed {
    logic seq_err;
    logic cmd_err;
    logic timeout;
    logic ext;
  } ssfl_fault_type;

  // synchronised pin inputs
  typedef struct packed {
    logic on_cmd;
    logic fault_low;
    logic prev_done;
    logic [NUM_CH-1:0] supply_sense;
  } ssfl_pins_type;
endpackage

/* logic/ssfl_sync.sv */
`timescale 1ns/10ps
// three-stage synchroniser; output changes once stages two and three agree
module ssfl_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // all state of the synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ssfl_sync_type;
  ssfl_sync_type st_r;
  ssfl_sync_type st_nxt;

  // shift and agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule

/* logic/ssfl_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: power-up waits step delay after sense up
// RULE_02: power-down waits step delay after sense down
// RULE_03: zero step delay uses minimum delay
// RULE_04: timeout counter starts at each enable
// RULE_05: timeout counter resets when sense rises
// RULE_06: timeout checked only during power-up
// RULE_07: zero timeout disables power-good checking
// RULE_08: integrator keeps timeout 1 to 100 delays
// RULE_09: cascade strap marks non-first devices
// RULE_10: shared wired-AND fault line, one pull-up
// RULE_11: done to next on link only
// RULE_12: unused channels loop enable to sense
// RULE_13: detect sequence, command, timeout, external faults
// RULE_14: any fault drops all enables at once
// RULE_15: internal fault drives fault line low
// RULE_16: fault held until inputs low, line free
// RULE_17: sense means on in up, off down
// RULE_18: power-down in reverse order, no timeout
// RULE_19: done asserted after up, released after down
// RULE_20: on rising starts up, falling starts down
// RULE_21: external fault: drop enables, hold line low
// RULE_22: counters loaded from parameters, zero special
module ssfl_top
  import ssfl_pkg::*;
#(
  parameter logic [CNT_W-1:0] STEP_DELAY = CNT_W'(STEP_DELAY_CYC), // zero = minimum
  parameter logic [CNT_W-1:0] PG_TIMEOUT = CNT_W'(PGT_CYC) // zero = disabled
) (
  clk,
  rstn,
  on_cmd,
  supply_sense,
  fault_in,
  hysteresis_cascade_strap,
  supply_enable,
  fault_out,
  fault_oe,
  done_n_out,
  done_n_oe,
  fault_internal,
  fault_class
);
  import ssfl_pkg::*;
  input wire logic clk; // 25 MHz
  input wire logic rstn; // async reset, active low
  input wire logic on_cmd; // comparator: on command above threshold
  input wire logic [NUM_CH-1:0] supply_sense; // comparators: supply above threshold
  input wire logic fault_in; // level of the shared fault line
  input wire logic hysteresis_cascade_strap; // high: not first in cascade
  output logic [NUM_CH-1:0] supply_enable; // supply enables
  output logic fault_out; // always low when driven (open drain)
  output logic fault_oe; // pulls fault line low
  output logic done_n_out; // always low when driven (open drain)
  output logic done_n_oe; // pulls done low
  output logic fault_internal; // fault detected here, not commanded
  output ssfl_fault_type fault_class; // latched fault class

  // reset release through two flops
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // synchronise every pin input
  ssfl_pins_type pins;
  logic [NUM_CH+2:0] raw_in;
  logic [NUM_CH+2:0] syn_in;
  assign raw_in = {on_cmd, ~fault_in, hysteresis_cascade_strap, supply_sense};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH + 3; gi++) begin : g_sync
      ssfl_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(raw_in[gi]),
        .dout(syn_in[gi])
      );
    end
  endgenerate
  assign pins = syn_in;

  // all state of the sequencer
  typedef struct packed {
    ssfl_state_type state;
    logic [1:0] ch; // channel being stepped
    logic [CNT_W-1:0] dly_cnt; // step delay counter
    logic [CNT_W-1:0] pg_cnt; // power-good counter
    logic [NUM_CH-1:0] en;
    logic drive_fault;
    logic done;
    logic internal;
    ssfl_fault_type cls;
    logic not_first; // strap caught after reset
    logic strap_done;
  } ssfl_core_type;
  ssfl_core_type st_r;
  ssfl_core_type st_nxt;

  logic [CNT_W-1:0] dly_load;
  logic pg_on;
  logic ext_fault;
  logic all_low;
  assign dly_load = (STEP_DELAY == CNT_ZERO) ? MIN_DELAY : STEP_DELAY; // RULE_03 RULE_22
  assign pg_on = (PG_TIMEOUT != CNT_ZERO); // RULE_07 RULE_22
  // external fault: line low while we do not drive it
  assign ext_fault = pins.fault_low && !st_r.drive_fault; // RULE_21
  assign all_low = (pins.supply_sense == ALL_OFF) && !pins.on_cmd;

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    // strap is static; follow it while idle so the synchroniser has settled
    if (st_r.state == SS_IDLE) begin
      st_nxt.not_first = pins.prev_done; // RULE_09
      st_nxt.strap_done = 1'b1;
    end
    case (st_r.state)
      SS_IDLE: begin
        if (pins.on_cmd) begin // RULE_20
          st_nxt.state = SS_UP_DLY;
          st_nxt.ch = CH_FIRST;
          st_nxt.dly_cnt = dly_load;
        end
      end
      SS_UP_DLY: begin
        if (!pins.on_cmd) begin
          st_nxt.cls.cmd_err = 1'b1; // RULE_13
        end else if (st_r.dly_cnt > MIN_DELAY) begin
          st_nxt.dly_cnt = st_r.dly_cnt - MIN_DELAY; // RULE_01
        end else begin
          st_nxt.en[st_r.ch] = 1'b1;
          st_nxt.pg_cnt = PG_TIMEOUT; // RULE_04
          st_nxt.state = SS_UP_WAIT;
        end
      end
      SS_UP_WAIT: begin
        if (!pins.on_cmd) begin
          st_nxt.cls.cmd_err = 1'b1;
        end else if (pins.supply_sense[st_r.ch]) begin // RULE_17
          st_nxt.pg_cnt = PG_TIMEOUT; // RULE_05
          st_nxt.dly_cnt = dly_load;
          if (st_r.ch == CH_LAST) begin
            st_nxt.state = SS_ON;
            st_nxt.done = 1'b1; // RULE_19
          end else begin
            st_nxt.ch = st_r.ch + 2'h1;
            st_nxt.state = SS_UP_DLY;
          end
        end else if (pg_on) begin // RULE_06
          if (st_r.pg_cnt > MIN_DELAY) begin
            st_nxt.pg_cnt = st_r.pg_cnt - MIN_DELAY;
          end else begin
            st_nxt.cls.timeout = 1'b1; // RULE_13
          end
        end
      end
      SS_ON: begin
        if (!pins.on_cmd) begin // RULE_20
          st_nxt.state = SS_DN_DLY;
          st_nxt.ch = CH_LAST; // RULE_18
          st_nxt.dly_cnt = dly_load;
        end
      end
      SS_DN_DLY: begin
        if (pins.on_cmd) begin
          st_nxt.cls.cmd_err = 1'b1;
        end else if (st_r.dly_cnt > MIN_DELAY) begin
          st_nxt.dly_cnt = st_r.dly_cnt - MIN_DELAY; // RULE_02
        end else begin
          st_nxt.en[st_r.ch] = 1'b0; // RULE_18
          st_nxt.state = SS_DN_WAIT;
        end
      end
      SS_DN_WAIT: begin
        if (pins.on_cmd) begin
          st_nxt.cls.cmd_err = 1'b1;
        end else if (!pins.supply_sense[st_r.ch]) begin // RULE_17
          st_nxt.dly_cnt = dly_load;
          if (st_r.ch == CH_FIRST) begin
            st_nxt.state = SS_IDLE;
            st_nxt.done = 1'b0; // RULE_19
          end else begin
            st_nxt.ch = st_r.ch - 2'h1;
            st_nxt.state = SS_DN_DLY;
          end
        end
      end
      SS_FAULT: begin
        // hold the line while the command or any sense is up
        if (!all_low) begin
          st_nxt.drive_fault = 1'b1; // RULE_21
        end else if (st_r.drive_fault) begin
          st_nxt.drive_fault = 1'b0; // release, then watch the line
        end else if (!pins.fault_low) begin // RULE_16
          // own release has passed the synchroniser and nobody else pulls
          st_nxt.state = SS_IDLE;
          st_nxt.cls = '0;
          st_nxt.internal = 1'b0;
          st_nxt.done = 1'b0;
        end
      end
      default: begin
        st_nxt.state = SS_FAULT;
      end
    endcase
    // sequence errors: any supply down in SS_ON, or the previous channel dropped during power-up
    if ((st_r.state == SS_ON && pins.supply_sense != ALL_ON) ||
        ((st_r.state == SS_UP_DLY || st_r.state == SS_UP_WAIT) &&
         st_r.ch != CH_FIRST && !pins.supply_sense[st_r.ch - 2'h1])) begin
      st_nxt.cls.seq_err = 1'b1; // RULE_13
    end
    if (st_r.state != SS_FAULT && ext_fault) begin
      st_nxt.cls.ext = 1'b1; // RULE_13
    end
    if (st_r.state != SS_FAULT && st_nxt.cls != '0) begin
      st_nxt.state = SS_FAULT;
      st_nxt.en = ALL_OFF; // RULE_14
      st_nxt.drive_fault = 1'b1; // RULE_15 RULE_21
      st_nxt.internal = !st_nxt.cls.ext;
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: SS_IDLE, ch: CH_FIRST, dly_cnt: CNT_ZERO, pg_cnt: CNT_ZERO,
                en: ALL_OFF, drive_fault: 1'b0, done: 1'b0, internal: 1'b0,
                cls: '0, not_first: 1'b0, strap_done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops or tied low
  assign supply_enable = st_r.en;
  assign fault_out = 1'b0;
  assign fault_oe = st_r.drive_fault;
  assign done_n_out = 1'b0;
  assign done_n_oe = st_r.done; // RULE_11
  assign fault_internal = st_r.internal;
  assign fault_class = st_r.cls;

  // any fault drops all enables next cycle
  fault_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    (st_r.state != SS_FAULT && st_nxt.state == SS_FAULT) |=> supply_enable == ALL_OFF)
    else $error("enables not dropped on fault");
  fault_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    (st_r.state == SS_FAULT && !all_low) |-> fault_oe)
    else $error("fault line not driven");
  sequence up_step_s;
    st_r.state == SS_UP_WAIT && pins.on_cmd && pins.supply_sense[st_r.ch]
      && st_r.ch != CH_LAST && !pins.fault_low
      && (st_r.ch == CH_FIRST || pins.supply_sense[st_r.ch - 2'h1]);
  endsequence
  step_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    up_step_s |=> st_r.state == SS_UP_DLY && st_r.dly_cnt == dly_load)
    else $error("step delay not loaded");
  pg_reload_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (st_r.state == SS_UP_DLY && st_nxt.state == SS_UP_WAIT) |=> st_r.pg_cnt == PG_TIMEOUT)
    else $error("timeout not started");
  pg_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    !pg_on |-> !st_nxt.cls.timeout || st_r.cls.timeout)
    else $error("timeout with checking off");
  done_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
    (st_r.state == SS_ON) |-> done_n_oe)
    else $error("done not asserted");
  down_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    (st_r.state == SS_ON && st_nxt.state == SS_DN_DLY) |=> st_r.ch == CH_LAST)
    else $error("power-down not from last");
  fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    (st_r.state == SS_FAULT && !all_low) |=> st_r.state == SS_FAULT)
    else $error("fault cleared early");
endmodule

/* bench/ssfl_supply_model.sv */
`timescale 1ns/10ps
// supplies behind the enables; each sense follows its enable after a lag
module ssfl_supply_model
  import ssfl_pkg::*;
(
  clk,
  supply_enable,
  kill,
  supply_sense
);
  input wire logic clk; // system clock
  input wire logic [NUM_CH-1:0] supply_enable; // from the sequencer
  input wire logic [NUM_CH-1:0] kill; // forces a supply dead
  output logic [NUM_CH-1:0] supply_sense; // above-threshold flags
  int lag_r [NUM_CH]; // cycles that enable and sense have disagreed
  initial supply_sense = 4'h0;
  // sense copies enable six cycles later; a dead supply stays low
  always @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      lag_r[i] <= (supply_enable[i] == supply_sense[i]) ? 0 : lag_r[i] + 1;
      if (kill[i]) begin
        supply_sense[i] <= 1'b0; // dead supply
      end else if (lag_r[i] >= 5) begin
        supply_sense[i] <= supply_enable[i];
      end
    end
  end
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
// self-checking bench for the supply sequencer
module tb;
  import ssfl_pkg::*;
  localparam int STEP = 4; // short step delay
  localparam int POWER_GOOD_TIMEOUT = 40;
  logic clk, rstn, on_cmd, ext_pull, strap, fault_in, fault_out, fault_oe;
  logic done_n_out, done_n_oe, fault_internal;
  logic [NUM_CH-1:0] supply_sense, supply_enable, kill, en_q, sn_q;
  logic on2, foe2, done2; // second sequencer, zero settings
  logic [NUM_CH-1:0] sense2, en2, kill2;
  logic [5:0] mon; // watched: sense 0, enable 1, done of second; enable 1, fault drive, done
  ssfl_fault_type fault_class;
  int cyc, err_total, compares;
  int en_t [NUM_CH]; // cycle of last enable change
  int sn_t [NUM_CH]; // cycle of last sense change
  assign mon = {sense2[0], en2[1], done2, supply_enable[1], fault_oe, done_n_oe};
  assign fault_in = ~(fault_oe | ext_pull);
  ssfl_top #(.STEP_DELAY(24'h00_0004), .PG_TIMEOUT(24'h00_0028)) ssfl_top_i (
    .clk(clk), .rstn(rstn), .on_cmd(on_cmd), .supply_sense(supply_sense),
    .fault_in(fault_in), .hysteresis_cascade_strap(strap), .supply_enable(supply_enable),
    .fault_out(fault_out), .fault_oe(fault_oe), .done_n_out(done_n_out),
    .done_n_oe(done_n_oe), .fault_internal(fault_internal), .fault_class(fault_class));
  ssfl_supply_model ssfl_supply_model_i (
    .clk(clk), .supply_enable(supply_enable), .kill(kill), .supply_sense(supply_sense));
  // second sequencer with zero settings: minimum delay, no timeout
  ssfl_top #(.STEP_DELAY(24'h00_0000), .PG_TIMEOUT(24'h00_0000)) ssfl_top_min_i (
    .clk(clk), .rstn(rstn), .on_cmd(on2), .supply_sense(sense2),
    .fault_in(~foe2), .hysteresis_cascade_strap(1'b0), .supply_enable(en2),
    .fault_out(), .fault_oe(foe2), .done_n_out(),
    .done_n_oe(done2), .fault_internal(), .fault_class());
  ssfl_supply_model ssfl_supply_model_min_i (
    .clk(clk), .supply_enable(en2), .kill(kill2), .supply_sense(sense2));
  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // timestamps of every edge on the first sequencer's enables and senses, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    en_q <= supply_enable;
    sn_q <= supply_sense;
    for (int i = 0; i < NUM_CH; i++) begin
      if (supply_enable[i] !== en_q[i]) en_t[i] <= cyc;
      if (supply_sense[i] !== sn_q[i]) sn_t[i] <= cyc;
    end
    if (cyc > 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for a watched flag
  task automatic wt(int k, logic v);
    int n;
    n = 0;
    while (mon[k] !== v && n < 400) begin
      tick(1);
      n++;
    end
    chk("wait", n < 400, 1);
  endtask
  // gap between a sense edge and the next enable edge
  task gap(int a, int b);
    chk("gap", (a - b >= STEP + 1) && (a - b <= STEP + 8), 1);
  endtask
  task power_up;
    on_cmd = 1'b1;
    wt(0, 1'b1);
    for (int i = 1; i < NUM_CH; i++) begin
      gap(en_t[i], sn_t[i - 1]);
      chk("up order", en_t[i] > en_t[i - 1], 1);
    end
    chk("all on", supply_enable, ALL_ON);
  endtask
  task power_down;
    on_cmd = 1'b0;
    wt(0, 1'b0);
    tick(8);
    for (int i = 0; i < NUM_CH - 1; i++) begin
      gap(en_t[i], sn_t[i + 1]);
    end
    chk("all off", supply_enable, ALL_OFF);
    chk("no fault", fault_oe, 0);
  endtask
  // fault must hold until command and senses are low
  task clear_fault;
    on_cmd = 1'b0;
    kill = 4'h0;
    wt(1, 1'b0);
    tick(10);
    chk("cleared", {fault_oe, done_n_oe}, 0);
    chk("class clear", fault_class, 0);
  endtask
  task pg_timeout;
    kill = 4'h4;
    on_cmd = 1'b1;
    wt(1, 1'b1);
    chk("timeout", (cyc - en_t[2] >= POWER_GOOD_TIMEOUT - 1) && (cyc - en_t[2] <= POWER_GOOD_TIMEOUT + 5), 1);
    chk("to off", supply_enable, ALL_OFF);
    chk("to class", fault_class, 4'h2);
    chk("to own", fault_internal, 1);
    clear_fault();
  endtask
  task cmd_err;
    on_cmd = 1'b1;
    wt(2, 1'b1);
    on_cmd = 1'b0;
    wt(1, 1'b1);
    chk("cmd class", fault_class, 4'h4);
    chk("cmd off", supply_enable, ALL_OFF);
    clear_fault();
  endtask
  task seq_err;
    power_up();
    kill = 4'h2;
    wt(1, 1'b1);
    chk("seq class", fault_class, 4'h8);
    chk("seq off", supply_enable, ALL_OFF);
    chk("seq own", fault_internal, 1);
    clear_fault();
  endtask
  task ext_fault;
    power_up();
    ext_pull = 1'b1;
    tick(8);
    chk("ext off", supply_enable, ALL_OFF);
    chk("ext drive", fault_oe, 1);
    chk("ext own", fault_internal, 0);
    chk("ext class", fault_class, 4'h1);
    chk("od low", {fault_out, done_n_out}, 2'h0);
    ext_pull = 1'b0;
    tick(20);
    chk("ext held", fault_oe, 1);
    // inputs low but the line still pulled elsewhere: fault must stay
    ext_pull = 1'b1;
    on_cmd = 1'b0;
    tick(30);
    chk("line held", fault_class, 4'h1);
    ext_pull = 1'b0;
    clear_fault();
  endtask
  // zero settings: minimum step delay, no power-good timeout
  task min_delay;
    int c;
    kill2 = 4'h4;
    on2 = 1'b1;
    wt(5, 1'b1);
    c = cyc;
    wt(4, 1'b1);
    // three-flop sync with agree, one state step, then the minimum delay
    chk("min gap", cyc - c, 5 + MIN_DELAY);
    tick(120);
    chk("no timeout", {foe2, en2}, 5'h07);
    kill2 = 4'h0;
    wt(3, 1'b1);
    on2 = 1'b0;
    wt(3, 1'b0);
    chk("min off", {foe2, en2}, 5'h00);
  endtask
  task wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // reset, then every scenario in turn
  initial begin
    rstn = 1'b0;
    on_cmd = 1'b0;
    ext_pull = 1'b0;
    strap = 1'b0; // first device in a cascade
    kill = 4'h0;
    on2 = 1'b0;
    kill2 = 4'h0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    tick(6);
    power_up();
    power_down();
    pg_timeout();
    cmd_err();
    seq_err();
    ext_fault();
    min_delay();
    wrap_up();
  end
endmodule
